/* File: dv/sse_engine_tb_top.sv */
`timescale 1ns/10ps
module sse_engine_tb_top;
  localparam logic [9:0] A_CTRL = {sse_pkg::IDX_CTRL, 2'b00};
  localparam logic [9:0] A_STAT = {sse_pkg::IDX_STAT, 2'b00};
  localparam logic [9:0] A_DATA = {sse_pkg::IDX_DATA, 2'b00};
  localparam logic [9:0] A_ADDR = {sse_pkg::IDX_ADDR, 2'b00};
  localparam logic [9:0] A_RATE = {sse_pkg::IDX_RATE, 2'b00};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  sse_pkg::sse_shev_type sh_ev;
  sse_pkg::sse_req_type sh_req;
  logic scl_drv;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  logic sda_in;
  logic [31:0] v;
  int n_mismatch = 0;
  int n_compared = 0;
  // Open drain: the wire follows whoever pulls it low
  assign sda_in = sda_oe ? (sda_out & sda_drv) : sda_drv;
  always #10 mclk = ~mclk;
  sse_engine #(.BFT_W(12)) u_sse_engine (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sh_ev(sh_ev), .sh_req(sh_req), .scl_in(scl_drv), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe));
  sse_far_model u_sse_far_model (.mclk(mclk), .sh_req(sh_req), .sda_line(sda_in), .sh_ev(sh_ev),
    .scl_drv(scl_drv), .sda_drv(sda_drv));
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until a rising edge sees waitrequest low; that edge takes it, only the watchdog ends a hang
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Unless kind is 7, load data and write control (clearing the event flag); act on the bus, then read the code if one is expected
  task automatic run(input logic [7:0] ctl, input logic [7:0] dat, input int kind, input logic ack,
    input logic [7:0] rx, input int exp);
    int i;
    if (kind != 7)
    begin
      acc(1'b1, A_DATA, dat, v);
      acc(1'b1, A_CTRL, ctl, v);
    end
    u_sse_far_model.act(kind, ack, rx);
    if (exp >= 0)
    begin
      v = '0;
      for (i = 0; i < 40 && v[sse_pkg::B_SI] !== 1'b1; i++) acc(1'b0, A_CTRL, 8'h00, v);
      check("event_flag", {31'h0, v[sse_pkg::B_SI]}, 32'h1);
      acc(1'b0, A_STAT, 8'h00, v);
      check("state_code", v, 32'(exp));
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial
  begin
    repeat (40000) @(posedge mclk);
    $display("watchdog expired");
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    acc(1'b0, A_STAT, 8'h00, v);
    check("status_reset", v, 32'hf8);
    acc(1'b0, A_CTRL, 8'h00, v);
    check("ctrl_reset", v, 32'h0);
    acc(1'b1, A_STAT, 8'h55, v);
    acc(1'b0, A_STAT, 8'h00, v);
    check("status_kept", v, 32'hf8);
    acc(1'b0, 10'h3fc, 8'h00, v);
    check("unmapped", v, sse_pkg::RD_UNMAPPED);
    done("reset");
    run(8'h60, 8'ha4, 0, 1'b0, 8'h00, 8'h08);
    run(8'h40, 8'ha4, 1, 1'b1, 8'ha4, 8'h18);
    run(8'h40, 8'h5a, 1, 1'b1, 8'h5a, 8'h28);
    run(8'h40, 8'h00, 7, 1'b1, 8'h33, 8'h28);
    run(8'h40, 8'h5b, 1, 1'b0, 8'h5b, 8'h30);
    run(8'h60, 8'ha5, 0, 1'b0, 8'h00, 8'h10);
    run(8'h40, 8'ha5, 1, 1'b0, 8'ha5, 8'h48);
    acc(1'b1, A_CTRL, 8'h70, v);
    // The request register follows the control write one edge later
    repeat (2) @(negedge mclk);
    check("stop_first", {30'h0, sh_req.gen_stop, sh_req.gen_start}, 32'h2);
    u_sse_far_model.act(4, 1'b0, 8'h00);
    acc(1'b0, A_CTRL, 8'h00, v);
    check("stop_cleared", {31'h0, v[sse_pkg::B_STO]}, 32'h0);
    run(8'h60, 8'ha4, 0, 1'b0, 8'h00, 8'h08);
    run(8'h40, 8'ha4, 1, 1'b0, 8'ha4, 8'h20);
    run(8'h60, 8'ha5, 0, 1'b0, 8'h00, 8'h10);
    run(8'h44, 8'ha5, 1, 1'b1, 8'ha5, 8'h40);
    run(8'h44, 8'h00, 8, 1'b0, 8'h77, -1);
    check("ack_driven", {31'h0, u_sse_far_model.ack_lvl}, 32'h0);
    run(8'h44, 8'h00, 1, 1'b1, 8'h77, 8'h50);
    run(8'h40, 8'h00, 8, 1'b0, 8'h66, -1);
    check("ack_released", {31'h0, u_sse_far_model.ack_lvl}, 32'h1);
    run(8'h40, 8'h00, 1, 1'b0, 8'h66, 8'h58);
    run(8'h40, 8'h00, 2, 1'b0, 8'h00, 8'h38);
    run(8'h50, 8'h00, 4, 1'b0, 8'h00, -1);
    done("master");
    acc(1'b1, A_ADDR, 8'h35, v);
    // Arbitration lost inside our address byte stays silent until that address byte is complete
    run(8'h60, 8'ha4, 0, 1'b0, 8'h00, 8'h08);
    run(8'h40, 8'ha4, 2, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 1, 1'b1, 8'h34, 8'h68);
    run(8'h54, 8'h00, 9, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 3, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 8, 1'b0, 8'h34, -1);
    check("addr_ack", {31'h0, u_sse_far_model.ack_lvl}, 32'h0);
    run(8'h44, 8'h00, 1, 1'b1, 8'h34, 8'h60);
    run(8'h44, 8'h00, 1, 1'b1, 8'h11, 8'h80);
    run(8'h40, 8'h00, 1, 1'b0, 8'h88, 8'h88);
    run(8'h44, 8'h00, 4, 1'b0, 8'h00, 8'ha0);
    run(8'h44, 8'h00, 3, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 1, 1'b1, 8'h00, 8'h70);
    run(8'h44, 8'h00, 1, 1'b1, 8'h55, 8'h90);
    run(8'h40, 8'h00, 1, 1'b0, 8'h56, 8'h98);
    run(8'h54, 8'h00, 9, 1'b0, 8'h00, -1);
    acc(1'b0, A_CTRL, 8'h00, v);
    check("stop_no_flag", {31'h0, v[sse_pkg::B_SI]}, 32'h0);
    run(8'h54, 8'h00, 4, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 3, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 1, 1'b1, 8'h35, 8'ha8);
    run(8'h44, 8'h3c, 1, 1'b1, 8'h3c, 8'hb8);
    run(8'h44, 8'h3d, 1, 1'b0, 8'h3d, 8'hc0);
    run(8'h54, 8'h00, 4, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 3, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 1, 1'b1, 8'h35, 8'ha8);
    run(8'h40, 8'h3e, 1, 1'b1, 8'h3e, 8'hc8);
    run(8'h54, 8'h00, 4, 1'b0, 8'h00, -1);
    done("slave");
    run(8'h44, 8'h00, 3, 1'b0, 8'h00, -1);
    run(8'h44, 8'h00, 6, 1'b0, 8'h00, 8'h00);
    run(8'h54, 8'h00, 4, 1'b0, 8'h00, -1);
    acc(1'b1, A_RATE, 8'hff, v);
    run(8'h44, 8'h00, 3, 1'b0, 8'h00, -1);
    run(8'h46, 8'h00, 5, 1'b0, 8'h00, 8'hd0);
    run(8'h54, 8'h00, 4, 1'b0, 8'h00, -1);
    done("faults");
    tally_and_finish();
  end
endmodule

/* File: dv/sse_far_model.sv */
`timescale 1ns/10ps
module sse_far_model (
  input wire logic mclk,
  input wire sse_pkg::sse_req_type sh_req,
  input wire logic sda_line,
  output sse_pkg::sse_shev_type sh_ev,
  output logic scl_drv,
  output logic sda_drv
);
  logic ack_lvl;
  initial
  begin
    sh_ev = '0;
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    ack_lvl = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Lines move only while SCL is low, except where a START or STOP is meant
  task automatic act(input int kind, input logic ack, input logic [7:0] rx);
    int i;
    case (kind)
      0, 1, 2, 7:
      begin
        // Kind 7 ignores hold on purpose, so its event must be lost
        for (i = 0; i < 200 && sh_req.hold !== 1'b0 && kind != 7; i++) tick(1);
        tick(1);
        sh_ev.rx_byte <= rx;
        sh_ev.ack_seen <= ack;
        sh_ev.start_sent <= kind == 0;
        sh_ev.byte_done <= kind == 1 || kind == 7;
        sh_ev.arb_lost <= kind == 2;
        tick(1);
        sh_ev.start_sent <= 1'b0;
        sh_ev.byte_done <= 1'b0;
        sh_ev.arb_lost <= 1'b0;
      end
      3:
      begin
        tick(1);
        sda_drv <= 1'b0;
        tick(3);
        scl_drv <= 1'b0;
      end
      4:
      begin
        tick(1);
        scl_drv <= 1'b0;
        sda_drv <= 1'b0;
        tick(3);
        scl_drv <= 1'b1;
        tick(3);
        sda_drv <= 1'b1;
      end
      5:
      begin
        tick(1);
        scl_drv <= 1'b1;
        tick(60);
      end
      6:
      begin
        tick(1);
        sh_ev.byte_active <= 1'b1;
        sda_drv <= 1'b1;
        tick(2);
        scl_drv <= 1'b1;
        tick(2);
        sda_drv <= 1'b0;
        tick(3);
        sh_ev.byte_active <= 1'b0;
        scl_drv <= 1'b0;
      end
      8:
      begin
        tick(1);
        scl_drv <= 1'b0;
        sda_drv <= 1'b1;
        sh_ev.rx_byte <= rx;
        tick(1);
        sh_ev.ack_cycle <= 1'b1;
        tick(3);
        scl_drv <= 1'b1;
        @(negedge mclk);
        ack_lvl = sda_line;
        tick(1);
        scl_drv <= 1'b0;
        tick(1);
        sh_ev.ack_cycle <= 1'b0;
      end
      default: tick(4);
    endcase
    tick(2);
  endtask
endmodule

/* File: rtl/sse_cond.sv */
`timescale 1ns/10ps
module sse_cond #(
  parameter int BFT_W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] preset,
  output logic start_seen,
  output logic stop_seen,
  output logic bus_busy,
  output logic free_to
);

  if (BFT_W < sse_pkg::BFT_MIN_W)
  begin : g_chk
    $error("BFT_W too narrow for the bus free timeout");
  end

  logic scl_q, sda_q, busy_q, fired_q;
  logic [BFT_W-1:0] cnt_q, cnt_d, limit;
  wire st_w = scl_in && scl_q && sda_q && !sda_in;
  wire sp_w = scl_in && scl_q && !sda_q && sda_in;
  wire hit_w = scl_in && (cnt_q >= limit) && !fired_q;

  assign limit = BFT_W'(sse_pkg::BFT_MULT) * (BFT_W'(sse_pkg::BFT_BASE) - BFT_W'(preset));
  assign cnt_d = scl_in ? cnt_q + BFT_W'(1) : '0;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= '0;
      fired_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      cnt_q <= cnt_d;
      fired_q <= scl_in && (fired_q || hit_w);
      busy_q <= st_w || (busy_q && !sp_w && !hit_w);
    end
  end

  assign start_seen = st_w;
  assign stop_seen = sp_w;
  assign bus_busy = busy_q;
  assign free_to = hit_w;

endmodule

/* File: rtl/sse_engine.sv */
// Contract
// - Each of 28 bus states has a unique code in status bits 7..3.
// - Status code is meaningful only while the event flag is set.
// - Low three status bits read zero while the event flag is set.
// - Status resets to idle 0xF8; idle never sets the event flag.
// - Master reports 0x08 after START, 0x10 after repeated START.
// - Address plus write sent: 0x18 on ACK, 0x20 on NACK.
// - Master data byte sent: 0x28 on ACK, 0x30 on NACK.
// - Arbitration loss reports 0x38, or 0x68/0xB0 when own address follows, 0x78 when general call follows.
// - Address plus read sent: 0x40 on ACK, 0x48 on NACK.
// - Master receiver byte: 0x50 when acked, 0x58 when not.
// - Slave acks own write address with 0x60, general call with 0x70.
// - Slave byte: 0x80/0x88, after general call 0x90/0x98.
// - Addressed slave reports 0xA0 on STOP or repeated START.
// - Slave transmitter: 0xA8 on own read address, 0xB8/0xC0 per master ack.
// - Last slave byte with ack assert clear yet acked reports 0xC8.
// - Clock-high timer expiry from the rate preset reports 0xD0.
// - Misplaced START or STOP reports bus error 0x00.
// - Event flag set on each reporting state, cleared only by software.
// - Receiver ack cycle drives SDA low when ack assert set, releases it otherwise; a matched slave address is acked regardless.
// - Start and stop together send STOP then START while we own the bus; STOP seen clears stop.
// - Slave stop request leaves the transfer like a received STOP, but reports no 0xA0 and sets no event flag.
`timescale 1ns/10ps
module sse_engine #(
  parameter int BFT_W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire sse_pkg::sse_shev_type sh_ev,
  output sse_pkg::sse_req_type sh_req,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  logic wait_q, en_q, sta_q, sto_q, si_q, aa_q, fte_q, toe_q;
  logic maddr_q, saddr_q, arb_q, owner_q, sda_oe_q;
  logic [7:0] data_q, own_q, rate_q, code_q;
  logic [31:0] rdata_q;
  sse_pkg::sse_mode_type mode_q, mode_d;
  sse_pkg::sse_req_type req_q;
  logic start_seen, stop_seen, bus_busy, free_to;

  sse_cond #(.BFT_W(BFT_W)) u_cond (
    .mclk(mclk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .preset(rate_q),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .bus_busy(bus_busy),
    .free_to(free_to)
  );

  // Avalon slave: one wait cycle, then the request is taken
  wire req = avs_read || avs_write;
  wire take = req && !wait_q;
  wire [7:0] idx = avs_address[9:2];
  wire hit_ctrl = idx == sse_pkg::IDX_CTRL;
  wire hit_stat = idx == sse_pkg::IDX_STAT;
  wire hit_data = idx == sse_pkg::IDX_DATA;
  wire hit_addr = idx == sse_pkg::IDX_ADDR;
  wire hit_rate = idx == sse_pkg::IDX_RATE;
  wire wr_ctrl = take && avs_write && hit_ctrl;
  wire wr_data = take && avs_write && hit_data;
  wire wr_addr = take && avs_write && hit_addr;
  wire wr_rate = take && avs_write && hit_rate;
  wire [7:0] wd = avs_writedata[7:0];
  wire [7:0] ctrl_rd = {bus_busy, en_q, sta_q, sto_q, si_q, aa_q, fte_q, toe_q};
  wire [7:0] stat_rd = {code_q[7:3], sse_pkg::CODE_LOW_ZERO};
  wire [7:0] byte_rd = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : hit_data ? data_q :
                       hit_addr ? own_q : rate_q;
  wire mapped = hit_ctrl || hit_stat || hit_data || hit_addr || hit_rate;
  wire [31:0] rd_mux = mapped ? {24'h000000, byte_rd} : sse_pkg::RD_UNMAPPED;

  // Protocol progress only while the event flag is clear
  wire act = en_q && !si_q;
  wire slave_on = (mode_q == sse_pkg::M_SR) || (mode_q == sse_pkg::M_SRGC) || (mode_q == sse_pkg::M_ST);
  wire berr = act && (start_seen || stop_seen) && sh_ev.byte_active;
  wire fto = act && fte_q && free_to;
  wire slv_end = act && slave_on && (start_seen || stop_seen);
  wire slv_sto = act && slave_on && sto_q;
  wire arb = act && sh_ev.arb_lost;
  wire hi_pri = berr || fto || slv_end || slv_sto || arb;
  wire st_path = act && sh_ev.start_sent && !hi_pri;
  wire byte_path = act && sh_ev.byte_done && !hi_pri && !sh_ev.start_sent;
  wire own_match = sh_ev.rx_byte[7:1] == own_q[7:1];
  wire gc_match = (sh_ev.rx_byte == sse_pkg::RST_BYTE) && own_q[0];
  wire rx_side = (mode_q == sse_pkg::M_MR) || (mode_q == sse_pkg::M_SR) || (mode_q == sse_pkg::M_SRGC);

  logic ev_hit, maddr_d, saddr_d, arb_d, owner_d;
  logic [7:0] ev_code;

  always_comb
  begin
    ev_hit = 1'b0;
    ev_code = sse_pkg::C_IDLE;
    mode_d = mode_q;
    maddr_d = maddr_q;
    saddr_d = saddr_q || (act && start_seen && !owner_q);
    arb_d = arb_q;
    owner_d = owner_q && !(act && stop_seen);
    if (berr)
    begin
      ev_hit = 1'b1;
      ev_code = sse_pkg::C_BERR;
      mode_d = sse_pkg::M_IDLE;
      {maddr_d, saddr_d, arb_d, owner_d} = 4'h0;
    end
    else if (fto)
    begin
      ev_hit = 1'b1;
      ev_code = sse_pkg::C_FREE;
      mode_d = sse_pkg::M_IDLE;
      {maddr_d, saddr_d, arb_d, owner_d} = 4'h0;
    end
    else if (slv_end || slv_sto)
    begin
      ev_hit = slv_end;
      ev_code = sse_pkg::C_SSTOP;
      mode_d = sse_pkg::M_IDLE;
      saddr_d = slv_end && start_seen;
    end
    else if (arb)
    begin
      // Lost during our address byte: keep listening for our own address
      ev_hit = !maddr_q;
      ev_code = sse_pkg::C_ARB;
      mode_d = sse_pkg::M_IDLE;
      arb_d = maddr_q;
      saddr_d = maddr_q;
      {maddr_d, owner_d} = 2'h0;
    end
    else if (st_path)
    begin
      ev_hit = 1'b1;
      ev_code = owner_q ? sse_pkg::C_RSTART : sse_pkg::C_START;
      mode_d = sse_pkg::M_MT;
      {maddr_d, owner_d, saddr_d} = 3'b110;
    end
    else if (byte_path && maddr_q)
    begin
      ev_hit = 1'b1;
      maddr_d = 1'b0;
      if (data_q[0])
      begin
        ev_code = sh_ev.ack_seen ? sse_pkg::C_AR_ACK : sse_pkg::C_AR_NACK;
        mode_d = sse_pkg::M_MR;
      end
      else
      begin
        ev_code = sh_ev.ack_seen ? sse_pkg::C_AW_ACK : sse_pkg::C_AW_NACK;
        mode_d = sse_pkg::M_MT;
      end
    end
    else if (byte_path && saddr_q)
    begin
      saddr_d = 1'b0;
      arb_d = 1'b0;
      ev_hit = own_match || gc_match || arb_q;
      ev_code = sse_pkg::C_ARB;
      mode_d = sse_pkg::M_IDLE;
      if (own_match && sh_ev.rx_byte[0])
      begin
        ev_code = arb_q ? sse_pkg::C_ARB_SR : sse_pkg::C_SR;
        mode_d = sse_pkg::M_ST;
      end
      else if (own_match)
      begin
        ev_code = arb_q ? sse_pkg::C_ARB_SW : sse_pkg::C_SW;
        mode_d = sse_pkg::M_SR;
      end
      else if (gc_match)
      begin
        ev_code = arb_q ? sse_pkg::C_ARB_GC : sse_pkg::C_GC;
        mode_d = sse_pkg::M_SRGC;
      end
    end
    else if (byte_path)
    begin
      ev_hit = 1'b1;
      case (mode_q)
        sse_pkg::M_MT: ev_code = sh_ev.ack_seen ? sse_pkg::C_MT_ACK : sse_pkg::C_MT_NACK;
        sse_pkg::M_MR: ev_code = aa_q ? sse_pkg::C_MR_ACK : sse_pkg::C_MR_NACK;
        sse_pkg::M_SR: ev_code = aa_q ? sse_pkg::C_SR_ACK : sse_pkg::C_SR_NACK;
        sse_pkg::M_SRGC: ev_code = aa_q ? sse_pkg::C_GR_ACK : sse_pkg::C_GR_NACK;
        sse_pkg::M_ST: ev_code = !sh_ev.ack_seen ? sse_pkg::C_ST_NACK :
                                 aa_q ? sse_pkg::C_ST_ACK : sse_pkg::C_ST_LAST;
        default: ev_hit = 1'b0;
      endcase
    end
    else if (act && stop_seen)
    begin
      mode_d = sse_pkg::M_IDLE;
      {maddr_d, saddr_d, arb_d} = 3'h0;
    end
  end

  // Set by an event wins over a clearing write in the same cycle
  wire si_d = ev_hit || (si_q && !(wr_ctrl && !wd[sse_pkg::B_SI]));
  wire sto_clr = (act && stop_seen) || slv_sto;
  wire sto_d = wr_ctrl ? wd[sse_pkg::B_STO] : (sto_q && !sto_clr);
  // STOP first while we own the bus, START only once it is ours or free
  wire gen_stop = act && sto_q && owner_q;
  wire gen_start = act && sta_q && !(sto_q && owner_q) && (owner_q || !bus_busy);
  wire sda_oe_d = sh_ev.ack_cycle && ((rx_side && aa_q) || (saddr_q && (own_match || gc_match)));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      rdata_q <= sse_pkg::RD_UNMAPPED;
      {en_q, sta_q, sto_q, si_q, aa_q, fte_q, toe_q} <= 7'h00;
      {maddr_q, saddr_q, arb_q, owner_q, sda_oe_q} <= 5'h00;
      data_q <= sse_pkg::RST_BYTE;
      own_q <= sse_pkg::RST_BYTE;
      rate_q <= sse_pkg::RST_BYTE;
      code_q <= sse_pkg::C_IDLE;
      mode_q <= sse_pkg::M_IDLE;
      req_q <= '0;
    end
    else
    begin
      wait_q <= !(req && wait_q);
      if (req && wait_q && avs_read)
        rdata_q <= rd_mux;
      if (wr_ctrl)
        {en_q, sta_q, aa_q, fte_q, toe_q} <= {wd[sse_pkg::B_EN], wd[sse_pkg::B_STA], wd[sse_pkg::B_AA],
                                              wd[sse_pkg::B_FTE], wd[sse_pkg::B_TOE]};
      sto_q <= sto_d;
      si_q <= si_d;
      if (wr_data)
        data_q <= wd;
      else if (byte_path)
        data_q <= sh_ev.rx_byte;
      if (wr_addr)
        own_q <= wd;
      if (wr_rate)
        rate_q <= wd;
      // Status writes are dropped so a stray store cannot corrupt the code
      if (ev_hit)
        code_q <= ev_code;
      mode_q <= mode_d;
      {maddr_q, saddr_q, arb_q, owner_q} <= {maddr_d, saddr_d, arb_d, owner_d};
      sda_oe_q <= sda_oe_d;
      req_q <= '{gen_start: gen_start, gen_stop: gen_stop, hold: si_d};
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign sh_req = req_q;
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;

  chk_low_bits: assert property (@(posedge mclk) disable iff (!rst_n) si_q |-> stat_rd[2:0] == 3'h0)
    else $error("status low bits not zero");
  chk_idle_no_flag: assert property (@(posedge mclk) disable iff (!rst_n) ev_hit |-> ev_code != sse_pkg::C_IDLE)
    else $error("idle code raised the event flag");
  chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    si_q && !wr_ctrl |=> si_q)
    else $error("event flag cleared without software");
  chk_code_hold: assert property (@(posedge mclk) disable iff (!rst_n) si_q ##1 si_q |-> $stable(code_q))
    else $error("code changed while flag set");
  chk_stall_req: assert property (@(posedge mclk) disable iff (!rst_n)
    si_q && si_d |=> !sh_req.gen_start && !sh_req.gen_stop && sh_req.hold)
    else $error("bus request issued while stalled");
  chk_start_code: assert property (@(posedge mclk) disable iff (!rst_n)
    st_path |=> si_q && code_q == ($past(owner_q) ? sse_pkg::C_RSTART : sse_pkg::C_START))
    else $error("wrong START code");
  chk_mt_data: assert property (@(posedge mclk) disable iff (!rst_n)
    byte_path && !maddr_q && !saddr_q && mode_q == sse_pkg::M_MT
    |=> code_q == ($past(sh_ev.ack_seen) ? sse_pkg::C_MT_ACK : sse_pkg::C_MT_NACK))
    else $error("wrong master transmit code");
  chk_bus_error: assert property (@(posedge mclk) disable iff (!rst_n) berr |=> si_q && code_q == sse_pkg::C_BERR)
    else $error("bus error not reported");
  chk_ack_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    sh_ev.ack_cycle && !saddr_q && rx_side |=> sda_oe == $past(aa_q))
    else $error("ack level does not follow ack assert");
  chk_stop_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    act && stop_seen && !wr_ctrl |=> !sto_q)
    else $error("stop request not cleared by STOP");
  chk_bus_wait: assert property (@(posedge mclk) disable iff (!rst_n) req && wait_q |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  cov_start: cover property (@(posedge mclk) disable iff (!rst_n) st_path ##1 code_q == sse_pkg::C_START);
  cov_arb_own: cover property (@(posedge mclk) disable iff (!rst_n) ev_hit && ev_code == sse_pkg::C_ARB_SW);
  cov_slave_tx: cover property (@(posedge mclk) disable iff (!rst_n) ev_hit && ev_code == sse_pkg::C_ST_LAST);
  cov_free_to: cover property (@(posedge mclk) disable iff (!rst_n) fto);

endmodule

/* File: rtl/sse_pkg.sv */
package sse_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hc0;
  localparam logic [7:0] IDX_STAT = 8'hc1;
  localparam logic [7:0] IDX_DATA = 8'hc2;
  localparam logic [7:0] IDX_ADDR = 8'hc3;
  localparam logic [7:0] IDX_RATE = 8'hcf;

  // Control register bit positions
  localparam int B_BUSY = 7;
  localparam int B_EN = 6;
  localparam int B_STA = 5;
  localparam int B_STO = 4;
  localparam int B_SI = 3;
  localparam int B_AA = 2;
  localparam int B_FTE = 1;
  localparam int B_TOE = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [2:0] CODE_LOW_ZERO = 3'h0;

  // Status codes
  localparam logic [7:0] C_BERR = 8'h00;
  localparam logic [7:0] C_START = 8'h08;
  localparam logic [7:0] C_RSTART = 8'h10;
  localparam logic [7:0] C_AW_ACK = 8'h18;
  localparam logic [7:0] C_AW_NACK = 8'h20;
  localparam logic [7:0] C_MT_ACK = 8'h28;
  localparam logic [7:0] C_MT_NACK = 8'h30;
  localparam logic [7:0] C_ARB = 8'h38;
  localparam logic [7:0] C_AR_ACK = 8'h40;
  localparam logic [7:0] C_AR_NACK = 8'h48;
  localparam logic [7:0] C_MR_ACK = 8'h50;
  localparam logic [7:0] C_MR_NACK = 8'h58;
  localparam logic [7:0] C_SW = 8'h60;
  localparam logic [7:0] C_ARB_SW = 8'h68;
  localparam logic [7:0] C_GC = 8'h70;
  localparam logic [7:0] C_ARB_GC = 8'h78;
  localparam logic [7:0] C_SR_ACK = 8'h80;
  localparam logic [7:0] C_SR_NACK = 8'h88;
  localparam logic [7:0] C_GR_ACK = 8'h90;
  localparam logic [7:0] C_GR_NACK = 8'h98;
  localparam logic [7:0] C_SSTOP = 8'ha0;
  localparam logic [7:0] C_SR = 8'ha8;
  localparam logic [7:0] C_ARB_SR = 8'hb0;
  localparam logic [7:0] C_ST_ACK = 8'hb8;
  localparam logic [7:0] C_ST_NACK = 8'hc0;
  localparam logic [7:0] C_ST_LAST = 8'hc8;
  localparam logic [7:0] C_FREE = 8'hd0;
  localparam logic [7:0] C_IDLE = 8'hf8;

  // Bus free timeout: BFT_MULT * (BFT_BASE - preset) cycles of SCL high
  localparam int BFT_MULT = 10;
  localparam int BFT_BASE = 257;
  localparam int BFT_MIN_W = 12;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_MT = 3'b001,
    M_MR = 3'b010,
    M_SR = 3'b011,
    M_SRGC = 3'b100,
    M_ST = 3'b101
  } sse_mode_type;

  // Events from the bit-level shifter
  typedef struct packed {
    logic byte_done;
    logic ack_seen;
    logic ack_cycle;
    logic start_sent;
    logic arb_lost;
    logic byte_active;
    logic [7:0] rx_byte;
  } sse_shev_type;

  // Requests to the bit-level shifter
  typedef struct packed {
    logic gen_start;
    logic gen_stop;
    logic hold;
  } sse_req_type;

endpackage
